// ===== common/crs_pkg.sv
// constants, op codes and register map of the call/return execution block
// assumes a core with a byte-addressed program counter and a four-phase cycle
`default_nettype none
package crs_pkg;
  // widths of the core state this block owns
  localparam int PC_W  = 21;
  localparam int ACC_W = 8;
  localparam int FLG_W = 5;
  localparam int BSR_W = 4;
  localparam int HL_W  = 8;
  localparam int UL_W  = 5;
  localparam int IR_W  = 16;
  localparam int OFF_W = 11;
  localparam int STACK_DEPTH = 31;

  // op code patterns
  localparam logic [IR_W-1:0] OPC_PUSH   = 16'h0005;
  localparam logic [IR_W-1:0] OPC_POP    = 16'h0006;
  localparam logic [IR_W-1:0] OPC_RESET  = 16'h00FF;
  localparam logic [14:0]     OPC_RETIRQ = 15'h0008;
  localparam logic [7:0]      OPC_RETLIT = 8'h0C;
  localparam logic [4:0]      OPC_RELATIVE_SUBROUTINE_CALL  = 5'h1B;

  // program counter step per single-word instruction
  localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;

  // master clear values
  localparam logic [PC_W-1:0]  PC_RST  = 21'h0_0000;
  localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
  localparam logic [FLG_W-1:0] FLG_RST = 5'h00;
  localparam logic [BSR_W-1:0] BSR_RST = 4'h0;
  localparam logic [HL_W-1:0]  HL_RST  = 8'h00;
  localparam logic [UL_W-1:0]  UL_RST  = 5'h00;
  localparam logic             IRQ_RST = 1'b0;
  localparam logic             RUN_RST = 1'b1;

  // apb register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_CTRL  = 12'h000;
  localparam logic [ADDR_W-1:0] REG_PC    = 12'h004;
  localparam logic [ADDR_W-1:0] REG_TOP   = 12'h008;
  localparam logic [ADDR_W-1:0] REG_CORE  = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_LATCH = 12'h010;

  // field positions
  localparam int CTRL_RUN_LSB = 0;
  localparam int CORE_ACC_LSB = 0;
  localparam int CORE_FLG_LSB = 8;
  localparam int CORE_BSR_LSB = 16;
  localparam int CORE_LO_LSB  = 24;
  localparam int CORE_HI_LSB  = 25;
  localparam int LAT_HL_LSB   = 8;
  localparam int LAT_UL_LSB   = 16;

  typedef enum logic [1:0] {CRS_Q1, CRS_Q2, CRS_Q3, CRS_Q4} crs_qphase_t;
  typedef enum logic [2:0] {
    CRS_OP_OTHER, CRS_OP_PUSH, CRS_OP_POP, CRS_OP_RELATIVE_SUBROUTINE_CALL,
    CRS_OP_RESET, CRS_OP_RETIRQ, CRS_OP_RETLIT
  } crs_op_t;
endpackage
`default_nettype wire

// ===== design/crs_stack.sv
// return stack storage as a shift register, entry 0 is the top
// assumes push and pop are never asserted together
`default_nettype none
module crs_stack
  import crs_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int W     = PC_W
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         clear,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  output logic      [W-1:0] top,
  output logic      [W-1:0] second
);
  logic [W-1:0] entry [DEPTH];

  assign top    = entry[0];
  assign second = entry[1];

  // top entry
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      entry[0] <= '0;
    else if (clear)
      entry[0] <= '0;
    else if (push)
      entry[0] <= push_data;
    else if (pop)
      entry[0] <= entry[1];
  end

  // lower entries shift with push and pop
  for (genvar i = 1; i < DEPTH; i++)
  begin : g_lvl
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        entry[i] <= '0;
      else if (clear)
        entry[i] <= '0;
      else if (push)
        entry[i] <= entry[i-1];
      else if (pop)
        entry[i] <= (i == DEPTH - 1) ? '0 : entry[(i == DEPTH - 1) ? i : i + 1];
    end
  end
endmodule
`default_nettype wire

// ===== design/crs_exec.sv
// execution of stack save/discard, relative call, soft reset and returns
// assumes instruction words arrive synchronous to sys_clk, taken in phase one
// Operation
// - save op pushes pc plus 2 in one cycle, old top moves down
// - relative call carries an 11-bit signed word offset, -1024 to 1023
// - relative call pushes pc plus 2 before the pc changes
// - relative call loads pc plus 2 plus twice offset; second cycle idle
// - soft reset op restores master clear values except run, starting in phase two
// - interrupt return pops the stack into pc in phase four; two cycles
// - interrupt return sets the high or low priority interrupt enable
// - interrupt return with s set copies the three shadows back
// - interrupt return with s clear leaves accumulator, flags, bank alone
// - literal return writes its 8-bit literal to accumulator in phase four
// - literal return pops stack into pc; second cycle idle
// - returns leave both pc latch registers unchanged
// - discard op drops the stack top, the entry below becomes top
//
// The address map and the APB register port were left to the implementer.
`default_nettype none
module crs_exec
  import crs_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              instr_valid,
  input  wire logic [IR_W-1:0]   instr_word,
  input  wire logic              irq_from_high,
  input  wire logic [ACC_W-1:0]  accum_shadow,
  input  wire logic [FLG_W-1:0]  flags_shadow,
  input  wire logic [BSR_W-1:0]  bank_select_shadow,
  output logic                   instr_ready,
  output logic                   soft_reset,
  output logic      [PC_W-1:0]   pc,
  output logic      [PC_W-1:0]   stack_top,
  output logic      [ACC_W-1:0]  accum,
  output logic      [FLG_W-1:0]  status_flags,
  output logic      [BSR_W-1:0]  bank_select_reg,
  output logic                   high_prio_irq_enable,
  output logic                   low_prio_irq_enable,
  output logic      [HL_W-1:0]   pc_high_latch,
  output logic      [UL_W-1:0]   pc_upper_latch
);
  crs_qphase_t     qphase;
  crs_op_t         op;
  logic [IR_W-1:0] ir;
  logic            exec;
  logic            nop_cycle;
  logic            run;
  logic [PC_W-1:0] stack_next;
  logic [PC_W-1:0] rel_off;
  logic [31:0]     rdata_mux;
  logic            take;
  logic            at_q2;
  logic            at_q3;
  logic            at_q4;
  logic            rst_evt;
  logic            push;
  logic            pop;
  logic            wr_en;
  logic            core_wr;
  logic            lat_wr;

  function automatic crs_op_t decode(input logic [IR_W-1:0] w);
    if (w == OPC_PUSH)
      return CRS_OP_PUSH;
    else if (w == OPC_POP)
      return CRS_OP_POP;
    else if (w == OPC_RESET)
      return CRS_OP_RESET;
    else if (w[IR_W-1:1] == OPC_RETIRQ)
      return CRS_OP_RETIRQ;
    else if (w[IR_W-1:8] == OPC_RETLIT)
      return CRS_OP_RETLIT;
    else if (w[IR_W-1:OFF_W] == OPC_RELATIVE_SUBROUTINE_CALL)
      return CRS_OP_RELATIVE_SUBROUTINE_CALL;
    else
      return CRS_OP_OTHER;
  endfunction

  function automatic logic is_two(input crs_op_t o);
    return (o == CRS_OP_RELATIVE_SUBROUTINE_CALL) || (o == CRS_OP_RETIRQ) || (o == CRS_OP_RETLIT);
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_PC) || (a == REG_TOP) ||
           (a == REG_CORE) || (a == REG_LATCH);
  endfunction

  assign take    = (qphase == CRS_Q1) && instr_ready && instr_valid;
  assign at_q2   = exec && (qphase == CRS_Q2);
  assign at_q3   = exec && (qphase == CRS_Q3);
  assign at_q4   = exec && (qphase == CRS_Q4);
  assign rst_evt = at_q2 && (op == CRS_OP_RESET);
  assign push    = at_q2 && ((op == CRS_OP_PUSH) || (op == CRS_OP_RELATIVE_SUBROUTINE_CALL));
  assign pop     = (at_q3 && (op == CRS_OP_POP)) ||
                   (at_q4 && ((op == CRS_OP_RETIRQ) || (op == CRS_OP_RETLIT)));
  assign rel_off = {{(PC_W-OFF_W-1){ir[OFF_W-1]}}, ir[OFF_W-1:0], 1'b0};
  assign wr_en   = psel && penable && pready && pwrite && reg_hit(paddr);
  assign core_wr = wr_en && (paddr == REG_CORE) && !exec;
  assign lat_wr  = wr_en && (paddr == REG_LATCH) && !exec;

  crs_stack #(
    .DEPTH (DEPTH),
    .W     (PC_W)
  ) u_stack (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clear     (rst_evt),
    .push      (push),
    .pop       (pop),
    .push_data (pc + PC_STEP),
    .top       (stack_top),
    .second    (stack_next)
  );

  // four sub-phases per instruction cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      qphase <= CRS_Q1;
    else
    begin
      case (qphase)
        CRS_Q1:  qphase <= CRS_Q2;
        CRS_Q2:  qphase <= CRS_Q3;
        CRS_Q3:  qphase <= CRS_Q4;
        default: qphase <= CRS_Q1;
      endcase
    end
  end

  // instruction capture and cycle sequencing
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ir   <= '0;
      op   <= CRS_OP_OTHER;
      exec <= 1'b0;
    end
    else if (take)
    begin
      ir   <= instr_word;
      op   <= decode(instr_word);
      exec <= 1'b1;
    end
    else if (rst_evt || at_q4)
      exec <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      nop_cycle <= 1'b0;
    else if (qphase == CRS_Q4)
      nop_cycle <= at_q4 && is_two(op);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      instr_ready <= 1'b0;
    else if (qphase == CRS_Q4)
      instr_ready <= run && !(at_q4 && is_two(op));
    else
      instr_ready <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      soft_reset <= 1'b0;
    else
      soft_reset <= rst_evt;
  end

  // program counter update in phase four, soft reset clears it in phase two
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pc <= PC_RST;
    else if (rst_evt)
      pc <= PC_RST;
    else if (at_q4)
    begin
      case (op)
        CRS_OP_RELATIVE_SUBROUTINE_CALL:  pc <= pc + PC_STEP + rel_off;
        CRS_OP_RETIRQ: pc <= stack_top;
        CRS_OP_RETLIT: pc <= stack_top;
        default:       pc <= pc + PC_STEP;
      endcase
    end
  end

  // accumulator, flags and bank select
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accum           <= ACC_RST;
      status_flags    <= FLG_RST;
      bank_select_reg <= BSR_RST;
    end
    else if (rst_evt)
    begin
      accum           <= ACC_RST;
      status_flags    <= FLG_RST;
      bank_select_reg <= BSR_RST;
    end
    else if (at_q4 && (op == CRS_OP_RETIRQ) && ir[0])
    begin
      accum           <= accum_shadow;
      status_flags    <= flags_shadow;
      bank_select_reg <= bank_select_shadow;
    end
    else if (at_q4 && (op == CRS_OP_RETLIT))
      accum <= ir[ACC_W-1:0];
    else if (core_wr)
    begin
      accum           <= pwdata[CORE_ACC_LSB +: ACC_W];
      status_flags    <= pwdata[CORE_FLG_LSB +: FLG_W];
      bank_select_reg <= pwdata[CORE_BSR_LSB +: BSR_W];
    end
  end

  // interrupt enables, set by return wins over software
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      high_prio_irq_enable <= IRQ_RST;
      low_prio_irq_enable  <= IRQ_RST;
    end
    else if (rst_evt)
    begin
      high_prio_irq_enable <= IRQ_RST;
      low_prio_irq_enable  <= IRQ_RST;
    end
    else if (at_q4 && (op == CRS_OP_RETIRQ))
    begin
      if (irq_from_high)
        high_prio_irq_enable <= 1'b1;
      else
        low_prio_irq_enable <= 1'b1;
    end
    else if (core_wr)
    begin
      high_prio_irq_enable <= pwdata[CORE_HI_LSB];
      low_prio_irq_enable  <= pwdata[CORE_LO_LSB];
    end
  end

  // latches written only by software or reset
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_high_latch  <= HL_RST;
      pc_upper_latch <= UL_RST;
    end
    else if (rst_evt)
    begin
      pc_high_latch  <= HL_RST;
      pc_upper_latch <= UL_RST;
    end
    else if (lat_wr)
    begin
      pc_high_latch  <= pwdata[LAT_HL_LSB +: HL_W];
      pc_upper_latch <= pwdata[LAT_UL_LSB +: UL_W];
    end
  end

  // run control gates instruction intake
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      run <= RUN_RST;
    else if (wr_en && (paddr == REG_CTRL))
      run <= pwdata[CTRL_RUN_LSB];
  end

  // apb read data select
  always_comb
  begin
    rdata_mux = '0;
    case (paddr)
      REG_CTRL:  rdata_mux[CTRL_RUN_LSB] = run;
      REG_PC:    rdata_mux[PC_W-1:0] = pc;
      REG_TOP:   rdata_mux[PC_W-1:0] = stack_top;
      REG_CORE:
      begin
        rdata_mux[CORE_ACC_LSB +: ACC_W] = accum;
        rdata_mux[CORE_FLG_LSB +: FLG_W] = status_flags;
        rdata_mux[CORE_BSR_LSB +: BSR_W] = bank_select_reg;
        rdata_mux[CORE_LO_LSB]           = low_prio_irq_enable;
        rdata_mux[CORE_HI_LSB]           = high_prio_irq_enable;
      end
      REG_LATCH:
      begin
        rdata_mux[LAT_HL_LSB +: HL_W] = pc_high_latch;
        rdata_mux[LAT_UL_LSB +: UL_W] = pc_upper_latch;
      end
      default:   rdata_mux = '0;
    endcase
  end

  // apb slave, one wait-free access phase
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (psel && !penable)
    begin
      pready  <= 1'b1;
      pslverr <= !reg_hit(paddr);
      prdata  <= rdata_mux;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  push_save_a: assert property (
    at_q2 && (op == CRS_OP_PUSH) |=> (stack_top == $past(pc) + PC_STEP) &&
      (stack_next == $past(stack_top)) ##2 !nop_cycle && instr_ready == run)
    else $error("save op push wrong");

  relative_subroutine_call_sign_a: assert property (
    at_q4 && (op == CRS_OP_RELATIVE_SUBROUTINE_CALL) && ir[OFF_W-1] |=> pc <= $past(pc) || $past(pc) < 21'h0_0800)
    else $error("negative call offset went forward");

  relative_subroutine_call_push_a: assert property (
    at_q2 && (op == CRS_OP_RELATIVE_SUBROUTINE_CALL) |=> (stack_top == $past(pc) + PC_STEP) && $stable(pc)
      [*2])
    else $error("call return address wrong");

  relative_subroutine_call_target_a: assert property (
    at_q4 && (op == CRS_OP_RELATIVE_SUBROUTINE_CALL) |=> pc == $past(pc) + PC_STEP + $past(rel_off)
      ##0 (nop_cycle && !exec) [*4])
    else $error("call target or idle cycle wrong");

  soft_reset_a: assert property (
    at_q2 && (op == CRS_OP_RESET) |=> soft_reset && pc == PC_RST && accum == ACC_RST &&
      stack_top == PC_RST && pc_high_latch == HL_RST && !high_prio_irq_enable)
    else $error("soft reset incomplete");

  retirq_pop_a: assert property (
    at_q4 && (op == CRS_OP_RETIRQ) |=> pc == $past(stack_top) &&
      stack_top == $past(stack_next) ##4 !nop_cycle)
    else $error("interrupt return pop wrong");

  retirq_gie_a: assert property (
    at_q4 && (op == CRS_OP_RETIRQ) |=>
      ($past(irq_from_high) ? high_prio_irq_enable : low_prio_irq_enable))
    else $error("interrupt enable not set");

  shadow_load_a: assert property (
    at_q4 && (op == CRS_OP_RETIRQ) && ir[0] |=> accum == $past(accum_shadow) &&
      status_flags == $past(flags_shadow) && bank_select_reg == $past(bank_select_shadow))
    else $error("shadow restore wrong");

  shadow_keep_a: assert property (
    at_q4 && (op == CRS_OP_RETIRQ) && !ir[0] |=> $stable(accum) && $stable(status_flags) &&
      $stable(bank_select_reg))
    else $error("core regs changed without s");

  retlit_acc_a: assert property (
    at_q4 && (op == CRS_OP_RETLIT) |=> accum == $past(ir[ACC_W-1:0]))
    else $error("literal not written");

  retlit_pop_a: assert property (
    at_q4 && (op == CRS_OP_RETLIT) |=> pc == $past(stack_top) ##0 (!instr_ready) [*4])
    else $error("literal return pc or idle wrong");

  latch_hold_a: assert property (
    at_q4 && ((op == CRS_OP_RETIRQ) || (op == CRS_OP_RETLIT)) |=>
      $stable(pc_high_latch) && $stable(pc_upper_latch))
    else $error("pc latch changed on return");

  pop_drop_a: assert property (
    at_q3 && (op == CRS_OP_POP) |=> stack_top == $past(stack_next) ##1 pc == $past(pc, 2) +
      PC_STEP)
    else $error("discard op wrong");

  pc_step_a: assert property (
    at_q4 && !is_two(op) |=> pc == $past(pc) + PC_STEP)
    else $error("pc step wrong");

  cov_relative_subroutine_call_c:  cover property (at_q4 && (op == CRS_OP_RELATIVE_SUBROUTINE_CALL));
  cov_retirq_c: cover property (at_q4 && (op == CRS_OP_RETIRQ) && ir[0]);
  cov_retlit_c: cover property (at_q4 && (op == CRS_OP_RETLIT));
  cov_reset_c:  cover property (rst_evt);
endmodule
`default_nettype wire

// ===== testbench/crs_fetch_model.sv
// fetch pipeline and shadow register model feeding the execution block
// assumes instr_ready is high for one phase-1 cycle when a word may be taken
`default_nettype none
module crs_fetch_model
  import crs_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             instr_ready,
  output logic                  instr_valid,
  output logic      [IR_W-1:0]  instr_word,
  output logic                  irq_from_high,
  output logic      [ACC_W-1:0] accum_shadow,
  output logic      [FLG_W-1:0] flags_shadow,
  output logic      [BSR_W-1:0] bank_select_shadow
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    instr_valid = 1'b0;
    instr_word = 16'hffff;
    irq_from_high = 1'b0;
    accum_shadow = 8'h00;
    flags_shadow = 5'h00;
    bank_select_shadow = 4'h0;
  end

  // offer a word and hold it until the edge that takes it
  task automatic issue(input logic [IR_W-1:0] word);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= word;
    do @(posedge sys_clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    instr_word <= ~word;
  endtask

  // saved context seen by an interrupt return
  task automatic set_ctx(input logic hi, input logic [ACC_W-1:0] a,
                         input logic [FLG_W-1:0] f, input logic [BSR_W-1:0] b);
    @(posedge sys_clk);
    irq_from_high <= hi;
    accum_shadow <= a;
    flags_shadow <= f;
    bank_select_shadow <= b;
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_crs_exec.sv
// self-checking bench for the call/return execution block
// assumes the fetch model instance supplies words and shadow values
`default_nettype none
module test_crs_exec
  import crs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              instr_valid;
  logic [IR_W-1:0]   instr_word;
  logic              irq_from_high;
  logic [ACC_W-1:0]  accum_shadow;
  logic [FLG_W-1:0]  flags_shadow;
  logic [BSR_W-1:0]  bank_select_shadow;
  logic              instr_ready;
  logic              soft_reset;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   stack_top;
  logic [ACC_W-1:0]  accum;
  logic [FLG_W-1:0]  status_flags;
  logic [BSR_W-1:0]  bank_select_reg;
  logic              high_prio_irq_enable;
  logic              low_prio_irq_enable;
  logic [HL_W-1:0]   pc_high_latch;
  logic [UL_W-1:0]   pc_upper_latch;
  logic [31:0]       rd;
  logic              err;
  int                cyc = 0;
  int                t_last = 0;
  int                gap;
  int                n_errors = 0;
  int                compares = 0;

  crs_exec u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word), .irq_from_high(irq_from_high),
    .accum_shadow(accum_shadow), .flags_shadow(flags_shadow),
    .bank_select_shadow(bank_select_shadow), .instr_ready(instr_ready),
    .soft_reset(soft_reset), .pc(pc), .stack_top(stack_top), .accum(accum),
    .status_flags(status_flags), .bank_select_reg(bank_select_reg),
    .high_prio_irq_enable(high_prio_irq_enable), .low_prio_irq_enable(low_prio_irq_enable),
    .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch)
  );

  crs_fetch_model u_fetch (
    .sys_clk(sys_clk), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_word(instr_word), .irq_from_high(irq_from_high), .accum_shadow(accum_shadow),
    .flags_shadow(flags_shadow), .bank_select_shadow(bank_select_shadow)
  );

  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
    cyc <= cyc + 1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue one word and note the cycles since the previous take
  task automatic op(input logic [IR_W-1:0] w);
    u_fetch.issue(w);
    gap = cyc - t_last;
    t_last = cyc;
  endtask

  task automatic wait_after(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    end_of_test;
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    apb(1'b0, REG_PC, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, REG_PC, 32'h0000_0123);
    apb(1'b1, REG_LATCH, 32'h001f_ab00);
    apb(1'b0, REG_PC, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, REG_LATCH, 32'h0000_0000);
    check(rd, 32'h001f_ab00);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    $display("test registers done");

    op(OPC_PUSH);
    wait_after(1);
    check(32'(stack_top), 32'h0000_0002);
    op(OPC_PUSH);
    check(32'(gap), 32'h0000_0004);
    wait_after(3);
    check({stack_top, 11'h000}, {21'h00_0004, 11'h000});
    check(32'(pc), 32'h0000_0004);
    op(OPC_POP);
    wait_after(3);
    check(32'(stack_top), 32'h0000_0002);
    check(32'(pc), 32'h0000_0006);
    $display("test save and discard done");

    op({OPC_RELATIVE_SUBROUTINE_CALL, 11'h400});
    wait_after(1);
    check(32'(stack_top), 32'h0000_0008);
    check(32'(pc), 32'h0000_0006);
    op({OPC_RETLIT, 8'ha5});
    check(32'(gap), 32'h0000_0008);
    wait_after(1);
    check(32'(pc), 32'h001f_f808);
    wait_after(2);
    check(32'(pc), 32'h0000_0008);
    check(32'(accum), 32'h0000_00a5);
    check(32'(stack_top), 32'h0000_0002);
    check({pc_upper_latch, pc_high_latch}, 32'h0000_1fab);
    $display("test call and literal return done");

    u_fetch.set_ctx(1'b1, 8'h5a, 5'h0a, 4'h6);
    op({OPC_RELATIVE_SUBROUTINE_CALL, 11'h3ff});
    wait_after(1);
    check(32'(stack_top), 32'h0000_000a);
    op({OPC_RETIRQ, 1'b1});
    check(32'(gap), 32'h0000_0008);
    wait_after(2);
    check(32'(pc), 32'h0000_0808);
    wait_after(1);
    check(32'(pc), 32'h0000_000a);
    check(32'(stack_top), 32'h0000_0002);
    check({accum, 3'h0, status_flags, 4'h0, bank_select_reg}, 32'h005a_0a06);
    check({high_prio_irq_enable, low_prio_irq_enable}, 32'h0000_0002);
    check({pc_upper_latch, pc_high_latch}, 32'h0000_1fab);
    $display("test interrupt return with shadows done");

    apb(1'b1, REG_CORE, 32'h0009_153c);
    u_fetch.set_ctx(1'b0, 8'hff, 5'h1f, 4'hf);
    op({OPC_RELATIVE_SUBROUTINE_CALL, 11'h000});
    wait_after(3);
    check(32'(pc), 32'h0000_000c);
    op({OPC_RETIRQ, 1'b0});
    wait_after(3);
    check(32'(pc), 32'h0000_000c);
    apb(1'b0, REG_CORE, 32'h0000_0000);
    check(rd, 32'h0109_153c);
    $display("test interrupt return plain done");

    op(OPC_RESET);
    wait_after(1);
    check(32'(soft_reset), 32'h0000_0001);
    check({pc, 3'h0, accum}, 32'h0000_0000);
    check(32'(stack_top), 32'h0000_0000);
    check({pc_upper_latch, pc_high_latch, low_prio_irq_enable}, 32'h0000_0000);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    op(16'h0000);
    wait_after(3);
    check(32'(pc), 32'h0000_0002);
    $display("test soft reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
